/* design/uebm_defs.vh */
// Constants for the endpoint bank manager: register offsets, fields, sizes.
// Included by the design; no logic here.
`ifndef UEBM_DEFS_VH
`define UEBM_DEFS_VH
`define UEBM_ADDR_CTRL 4'h0
`define UEBM_ADDR_STAT 4'h1
`define UEBM_ADDR_BCNT 4'h2
`define UEBM_ADDR_DATA 4'h3
`define UEBM_ADDR_FNUM 4'h4
`define UEBM_ADDR_CLR 4'h5
// Control bits
`define UEBM_C_DIR_IN 0
`define UEBM_C_AUTO 1
`define UEBM_C_DMA 2
`define UEBM_C_ISO 3
`define UEBM_C_ISO_FRAME_SWITCH 4
`define UEBM_C_DUAL 5
`define UEBM_C_OUTIE 6
`define UEBM_C_INIE 7
// Status bits
`define UEBM_S_OUTRX 0
`define UEBM_S_INRDY 1
`define UEBM_S_BUSY 2
`define UEBM_S_RW_ALLOWED 3
`define UEBM_S_ZLP 4
`define UEBM_S_UNDER 5
`define UEBM_S_OVER 6
`define UEBM_S_STCRC 7
`define UEBM_S_SOF 8
`define UEBM_S_KILL 9
`define UEBM_CTRL_RST 8'h00
`define UEBM_BANK_BYTES 7'h40
`define UEBM_SOF_GAP 16'h61a8
`define UEBM_SOF_MISS 16'h6590
`endif

/* design/uebm_top.v */
// Endpoint bank manager: two 64-byte banks, host side and local side.
// Assumes a classic Wishbone master and a byte-wide host packet interface.
`timescale 1ns/1ns
`include "uebm_defs.vh"
module uebm_top (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire hs_wr_i,
	input wire [7:0] hs_wdat_i,
	input wire hs_end_i,
	input wire hs_crc_err_i,
	input wire hs_rd_i,
	output reg [7:0] hs_rdat_o,
	output reg hs_last_o,
	output reg hs_empty_o,
	input wire sof_i,
	input wire dma_wr_i,
	input wire [7:0] dma_wdat_i,
	input wire dma_rd_i,
	output reg [7:0] dma_rdat_o,
	output reg endpoint_irq_o
);
	reg [7:0] mem [0:127];
	reg [7:0] ctrl;
	reg [6:0] cnt [0:1];
	reg [6:0] rptr [0:1];
	reg [1:0] full;
	reg [1:0] wlast;
	reg loc;
	reg hst;
	reg [6:0] hcnt;
	reg hdrop;
	reg hover;
	reg out_received_flag, in_ready_flag, bank_busy_ctl;
	reg zero_len_seen, underflow_flag, overflow_flag, stall_crc_flag, frame_start_flag;
	reg [10:0] frame_number;
	reg [15:0] sof_cnt;
	reg kill_done;
	wire is_in = ctrl[`UEBM_C_DIR_IN];
	wire auto_bank_switch = ctrl[`UEBM_C_AUTO];
	wire data_flow_dma = ctrl[`UEBM_C_DMA];
	wire is_iso = ctrl[`UEBM_C_ISO];
	wire iso_frame_switch = ctrl[`UEBM_C_ISO_FRAME_SWITCH] & is_in & is_iso;
	wire dual = ctrl[`UEBM_C_DUAL];

	// Last byte test for a bank pointer
	function last_byte;
		input [6:0] ptr;
		input [6:0] lim;
		last_byte = (ptr + 7'h01 == lim);
	endfunction
	wire wb_req = cyc_i & stb_i & ~ack_o;
	wire wb_wr = wb_req & we_i & sel_i[0];
	wire wb_rd = wb_req & ~we_i;
	wire cpu_rd = wb_rd & (adr_i == `UEBM_ADDR_DATA);
	wire cpu_wr = wb_wr & (adr_i == `UEBM_ADDR_DATA);
	wire clr_wr = wb_wr & (adr_i == `UEBM_ADDR_CLR);
	wire loc_rd = (cpu_rd | dma_rd_i) & ~is_in & full[loc] & (rptr[loc] != cnt[loc]);
	wire loc_wr = (cpu_wr | dma_wr_i) & is_in & ~full[loc] & (cnt[loc] != `UEBM_BANK_BYTES);
	wire [7:0] loc_wdat = dma_wr_i ? dma_wdat_i : dat_i[7:0];
	// Current bank open to local access
	wire rw_allowed = is_in ? (~full[loc] & (cnt[loc] != `UEBM_BANK_BYTES)) :
		(full[loc] & (rptr[loc] != cnt[loc]));

	// Status word as read by software
	wire [31:0] stat_word;
	assign stat_word[`UEBM_S_OUTRX] = out_received_flag;
	assign stat_word[`UEBM_S_INRDY] = in_ready_flag;
	assign stat_word[`UEBM_S_BUSY] = bank_busy_ctl;
	assign stat_word[`UEBM_S_RW_ALLOWED] = rw_allowed;
	assign stat_word[`UEBM_S_ZLP] = zero_len_seen;
	assign stat_word[`UEBM_S_UNDER] = underflow_flag;
	assign stat_word[`UEBM_S_OVER] = overflow_flag;
	assign stat_word[`UEBM_S_STCRC] = stall_crc_flag;
	assign stat_word[`UEBM_S_SOF] = frame_start_flag;
	assign stat_word[`UEBM_S_KILL] = kill_done;
	assign stat_word[31:10] = 22'h0;
	wire sw_busy_clr = clr_wr & dat_i[`UEBM_S_BUSY] & ~(auto_bank_switch | iso_frame_switch);
	wire auto_out_free = auto_bank_switch & loc_rd & last_byte(rptr[loc], cnt[loc]);
	wire auto_in_free = auto_bank_switch & loc_wr & last_byte(cnt[loc], `UEBM_BANK_BYTES);
	wire sof_miss = (sof_cnt == `UEBM_SOF_MISS);
	wire frame_tick = sof_i | sof_miss;
	wire iso_sw = iso_frame_switch & frame_tick & ~full[loc] & (cnt[loc] != 7'h00);
	wire loc_done = sw_busy_clr | auto_out_free | auto_in_free | iso_sw;
	wire kill = clr_wr & dat_i[`UEBM_S_KILL] & is_in;

	// Write-one clear strobes for the sticky flags; busy clear and kill are decoded above
	wire clr_outrx = clr_wr & dat_i[`UEBM_S_OUTRX];
	wire clr_inrdy = clr_wr & dat_i[`UEBM_S_INRDY];
	wire clr_zlp = clr_wr & dat_i[`UEBM_S_ZLP];
	wire clr_under = clr_wr & dat_i[`UEBM_S_UNDER];
	wire clr_over = clr_wr & dat_i[`UEBM_S_OVER];
	wire clr_stcrc = clr_wr & dat_i[`UEBM_S_STCRC];
	wire clr_sof = clr_wr & dat_i[`UEBM_S_SOF];

	// Host packet end on OUT
	wire hs_out_end = hs_end_i & ~is_in;
	wire zlp_filt = hs_out_end & (hcnt == 7'h00) & auto_bank_switch & data_flow_dma;
	wire h_commit = hs_out_end & ~hdrop & ~zlp_filt;
	wire h_in_rd = hs_rd_i & is_in & full[hst];
	wire h_in_last = h_in_rd & last_byte(rptr[hst], cnt[hst]);
	function nb;
		input d;
		input b;
		nb = d ? ~b : b;
	endfunction
	wire [1:0] bank_free_set;
	assign bank_free_set[0] = (loc_done & loc == 1'b0) | (h_in_last & hst == 1'b0);
	assign bank_free_set[1] = (loc_done & loc == 1'b1) | (h_in_last & hst == 1'b1);

	// State of the bank that follows; a single bank has none
	wire nxt_full = dual & full[~loc];
	wire nxt_free = dual & ~full[~loc];

	// OUT flags set by landed packet or full next bank
	wire out_flag_set = (h_commit & hst == loc) | (loc_done & nxt_full);

	// IN flags set on switch to free bank or freed bank
	wire in_flag_set = loc_done ? nxt_free : (~full[loc] & ~bank_busy_ctl);

	// Host reads an empty iso IN bank
	wire iso_in_under = hs_rd_i & is_in & is_iso & ~full[hst];

	// Iso OUT packet dropped for lack of a bank
	wire iso_out_under = hs_out_end & hdrop & is_iso;

	wire over_set = h_commit & (hover | (hs_wr_i & hcnt == `UEBM_BANK_BYTES));

	wire crc_set = h_commit & is_iso & hs_crc_err_i;

	// Kill accepted for the last switched IN bank while it is still full, unless host is taking that bank
	wire kill_ok = kill & wlast[0] & full[wlast[1]] & ~(h_in_rd & hst == wlast[1]);

	// Interrupt request ahead of its register
	wire irq_next = (out_received_flag & ctrl[`UEBM_C_OUTIE]) |
		(in_ready_flag & ctrl[`UEBM_C_INIE]);

	integer i;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `UEBM_CTRL_RST;
			ack_o <= 1'b0;
			dat_o <= 32'h0;
			full <= 2'b00;
			wlast <= 2'b00;
			loc <= 1'b0;
			hst <= 1'b0;
			hcnt <= 7'h00;
			hdrop <= 1'b0;
			hover <= 1'b0;
			for (i = 0; i < 2; i = i + 1) begin
				cnt[i] <= 7'h00;
				rptr[i] <= 7'h00;
			end
			out_received_flag <= 1'b0;
			in_ready_flag <= 1'b0;
			bank_busy_ctl <= 1'b0;
			zero_len_seen <= 1'b0;
			underflow_flag <= 1'b0;
			overflow_flag <= 1'b0;
			stall_crc_flag <= 1'b0;
			frame_start_flag <= 1'b0;
			frame_number <= 11'h000;
			sof_cnt <= 16'h0000;
			kill_done <= 1'b0;
			hs_rdat_o <= 8'h00;
			hs_last_o <= 1'b0;
			hs_empty_o <= 1'b1;
			dma_rdat_o <= 8'h00;
			endpoint_irq_o <= 1'b0;
		end else begin
			ack_o <= wb_req;
			hs_last_o <= h_in_last;
			if (wb_wr & (adr_i == `UEBM_ADDR_CTRL)) begin
				ctrl <= dat_i[7:0];
			end
			if (wb_rd) begin
				case (adr_i)
				`UEBM_ADDR_CTRL: dat_o <= {24'h0, ctrl};
				`UEBM_ADDR_STAT: dat_o <= stat_word;
				`UEBM_ADDR_BCNT: dat_o <= {25'h0, cnt[loc]};
				`UEBM_ADDR_DATA: dat_o <= {24'h0, mem[{loc, rptr[loc][5:0]}]};
				`UEBM_ADDR_FNUM: dat_o <= {21'h0, frame_number};
				default: dat_o <= 32'h0;
				endcase
			end
			sof_cnt <= frame_tick ? 16'h0000 : sof_cnt + 16'h0001;
			if (sof_miss) begin
				frame_number <= frame_number + 11'h001;
			end

			// Local side data path
			if (loc_rd) begin
				dma_rdat_o <= mem[{loc, rptr[loc][5:0]}];
				rptr[loc] <= rptr[loc] + 7'h01;
			end
			if (loc_wr) begin
				mem[{loc, cnt[loc][5:0]}] <= loc_wdat;
				cnt[loc] <= cnt[loc] + 7'h01;
			end

			// Host side OUT receive
			if (hs_wr_i & ~is_in) begin
				if (hcnt == 7'h00 && full[hst]) begin
					hdrop <= 1'b1;
				end else if (~hdrop) begin
					if (hcnt < `UEBM_BANK_BYTES) begin
						mem[{hst, hcnt[5:0]}] <= hs_wdat_i;
						hcnt <= hcnt + 7'h01;
					end else begin
						hover <= 1'b1;
					end
				end
			end

			// Host side IN send
			if (h_in_rd) begin
				hs_rdat_o <= mem[{hst, rptr[hst][5:0]}];
				rptr[hst] <= rptr[hst] + 7'h01;
			end

			// Pointer round robin and bank state
			for (i = 0; i < 2; i = i + 1) begin
				if (bank_free_set[i]) begin
					full[i] <= is_in ? ~full[i] : 1'b0;
					if (~is_in | full[i]) begin
						cnt[i] <= 7'h00;
					end
					rptr[i] <= 7'h00;
				end
			end
			if (loc_done) begin
				loc <= nb(dual, loc);
				if (is_in) begin
					wlast <= dual ? {loc, 1'b1} : {1'b0, 1'b1};
				end
			end
			if (h_in_last) begin
				hst <= nb(dual, hst);
			end
			if (hs_out_end) begin
				hcnt <= 7'h00;
				hdrop <= 1'b0;
				hover <= 1'b0;
				if (h_commit) begin
					full[hst] <= 1'b1;
					cnt[hst] <= hcnt;
					rptr[hst] <= 7'h00;
					hst <= nb(dual, hst);
				end
			end

			kill_done <= 1'b0;
			if (kill_ok) begin
				full[wlast[1]] <= 1'b0;
				cnt[wlast[1]] <= 7'h00;
				loc <= wlast[1];
				wlast <= 2'b00;
				kill_done <= 1'b1;
			end
			if (~is_in) begin
				if (out_flag_set) begin
					out_received_flag <= 1'b1;
					bank_busy_ctl <= 1'b1;
				end else begin
					if (clr_outrx) begin
						out_received_flag <= 1'b0;
					end
					if (loc_done) begin
						bank_busy_ctl <= 1'b0;
					end
				end
			end else begin
				if (in_flag_set) begin
					in_ready_flag <= 1'b1;
					bank_busy_ctl <= 1'b1;
				end else begin
					if (clr_inrdy) begin
						in_ready_flag <= 1'b0;
					end
					if (loc_done) begin
						bank_busy_ctl <= 1'b0;
					end
				end
			end

			// Write-one clears for the remaining sticky flags
			if (clr_zlp) begin
				zero_len_seen <= 1'b0;
			end
			if (clr_under) begin
				underflow_flag <= 1'b0;
			end
			if (clr_over) begin
				overflow_flag <= 1'b0;
			end
			if (clr_stcrc) begin
				stall_crc_flag <= 1'b0;
			end
			if (clr_sof) begin
				frame_start_flag <= 1'b0;
			end

			if (zlp_filt) begin
				zero_len_seen <= 1'b1;
			end

			if (iso_in_under | iso_out_under) begin
				underflow_flag <= 1'b1;
			end

			if (over_set) begin
				overflow_flag <= 1'b1;
			end

			if (crc_set) begin
				stall_crc_flag <= 1'b1;
			end
			if (frame_tick) begin
				frame_start_flag <= 1'b1;
			end
			hs_empty_o <= ~full[hst] | ~is_in;
			endpoint_irq_o <= irq_next;
		end
	end
endmodule // uebm_top

/* bench/uebm_assertions.sv */
// Port checker for the endpoint bank manager.
// Bound to uebm_top; sees its ports only.
`timescale 1ns/1ns
module uebm_checker (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire ack_o,
	input wire hs_rd_i,
	input wire [7:0] hs_rdat_o,
	input wire hs_last_o,
	input wire hs_empty_o,
	input wire sof_i,
	input wire dma_wr_i,
	input wire endpoint_irq_o
);
	reg [7:0] ctrl;
	always @(posedge clk_i) begin
		if (rst_i)
			ctrl <= 8'h00;
		else if (ack_o && we_i && adr_i == 4'h0 && sel_i[0])
			ctrl <= dat_i[7:0];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than a cycle");
	chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing");
	chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	chk_rdat_cause: assert property ($changed(hs_rdat_o) |-> $past(hs_rd_i))
		else $error("host data moved unasked");
	chk_last_cause: assert property (hs_last_o |-> $past(hs_rd_i))
		else $error("last without read");
	chk_last_empty: assert property (hs_last_o && !ctrl[5] |-> ##[0:2] hs_empty_o)
		else $error("bank not empty after last");
	chk_irq_masked: assert property (ctrl[7:6] == 2'h0 && $past(ctrl[7:6]) == 2'h0 |-> !endpoint_irq_o)
		else $error("irq while disabled");
	chk_bank_handed: assert property ($fell(hs_empty_o) && !ctrl[4] |-> ack_o || $past(ack_o)
		|| $past(ack_o, 2) || $past(dma_wr_i) || $past(dma_wr_i, 2) || $past(sof_i))
		else $error("bank handed unasked");
	cov_irq: cover property ($rose(endpoint_irq_o));
	cov_last: cover property (hs_last_o);
	cov_data_wr: cover property (ack_o && we_i && adr_i == 4'h3);
endmodule // uebm_checker
bind uebm_top uebm_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .hs_rd_i(hs_rd_i),
	.hs_rdat_o(hs_rdat_o), .hs_last_o(hs_last_o), .hs_empty_o(hs_empty_o), .sof_i(sof_i),
	.dma_wr_i(dma_wr_i), .endpoint_irq_o(endpoint_irq_o));

/* bench/uebm_host_model.sv */
// Host model: sends OUT packets, takes IN bytes.
// Drives the host strobes just after rising edges.
`timescale 1ns/1ns
module uebm_host_model (
	input wire clk_i,
	input wire [7:0] hs_rdat_i,
	input wire hs_last_i,
	output logic hs_wr_o = 1'b0,
	output logic [7:0] hs_wdat_o = 8'h00,
	output logic hs_end_o = 1'b0,
	output logic hs_rd_o = 1'b0
);
	task automatic send(input int n, input logic [7:0] b);
		for (int i = 0; i < n; i++) begin
			hs_wr_o <= 1'b1;
			hs_wdat_o <= b + i[7:0];
			@(posedge clk_i);
		end
		hs_wr_o <= 1'b0;
		hs_wdat_o <= ~hs_wdat_o;
		hs_end_o <= 1'b1;
		@(posedge clk_i);
		hs_end_o <= 1'b0;
	endtask
	task automatic take(output logic [7:0] d, output logic l);
		hs_rd_o <= 1'b1;
		@(posedge clk_i);
		hs_rd_o <= 1'b0;
		@(posedge clk_i);
		d = hs_rdat_i;
		l = hs_last_i;
	endtask
endmodule // uebm_host_model

/* bench/tb_usb_endpoint_bank_manager.sv */
// Testbench for the endpoint bank manager.
// Wishbone from here, host model on the far side; DMA reads driven, frame inputs idle.
`timescale 1ns/1ns
module tb_usb_endpoint_bank_manager;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] adr_i = 4'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	wire [31:0] dat_o;
	wire ack_o, hs_wr, hs_end, hs_rd, hs_last, hs_empty, irq;
	wire [7:0] hs_wdat, hs_rdat;
	logic [31:0] q;
	logic [7:0] b;
	logic l;
	logic dma_rd = 1'b0;
	wire [7:0] dma_rdat;
	int failures = 0;
	int samples_checked = 0;
	always #20 clk_i = ~clk_i;
	uebm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.hs_wr_i(hs_wr), .hs_wdat_i(hs_wdat), .hs_end_i(hs_end), .hs_crc_err_i(1'b0),
		.hs_rd_i(hs_rd), .hs_rdat_o(hs_rdat), .hs_last_o(hs_last), .hs_empty_o(hs_empty),
		.sof_i(1'b0), .dma_wr_i(1'b0), .dma_wdat_i(8'h00), .dma_rd_i(dma_rd),
		.dma_rdat_o(dma_rdat),
		.endpoint_irq_o(irq));
	uebm_host_model i_host (.clk_i(clk_i), .hs_rdat_i(hs_rdat), .hs_last_i(hs_last),
		.hs_wr_o(hs_wr), .hs_wdat_o(hs_wdat), .hs_end_o(hs_end), .hs_rd_o(hs_rd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 100);
		if (n >= 100)
			failures++;
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic in_manual;
		wb(1'b1, 4'h0, 32'h81);
		wb(1'b0, 4'h1, 32'h0);
		chk(q[3:1], 3'h7);
		chk(irq, 1'b1);
		wb(1'b1, 4'h3, 32'h5a);
		wb(1'b1, 4'h3, 32'ha5);
		wb(1'b1, 4'h5, 32'h2);
		wb(1'b1, 4'h5, 32'h4);
		wb(1'b0, 4'h1, 32'h0);
		chk(q[2:1], 2'h0);
		chk(hs_empty, 1'b0);
		i_host.take(b, l);
		chk(b, 8'h5a);
		i_host.take(b, l);
		chk({b, l}, {8'ha5, 1'b1});
		wb(1'b0, 4'h1, 32'h0);
		chk(q[3:1], 3'h7);
	endtask
	task automatic out_manual;
		wb(1'b1, 4'h0, 32'h40);
		i_host.send(3, 8'hc0);
		wb(1'b0, 4'h1, 32'h0);
		chk(q[3:0], 4'hd);
		chk(irq, 1'b1);
		wb(1'b0, 4'h2, 32'h0);
		chk(q, 32'h3);
		wb(1'b1, 4'h5, 32'h1);
		for (int i = 0; i < 3; i++) begin
			wb(1'b0, 4'h3, 32'h0);
			chk(q[7:0], 8'hc0 + i[7:0]);
		end
		wb(1'b0, 4'h1, 32'h0);
		chk(q[3], 1'b0);
	endtask
	task automatic overflow;
		i_host.send(65, 8'h00);
		wb(1'b0, 4'h1, 32'h0);
		chk({q[6], q[0]}, 2'h3);
		chk(irq, 1'b0);
		wb(1'b0, 4'h2, 32'h0);
		chk(q, 32'h40);
		wb(1'b0, 4'h3, 32'h0);
		chk(q[7:0], 8'h00);
		wb(1'b0, 4'hf, 32'h0);
		chk(q, 32'h0);
	endtask
	task automatic dma_drain(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			dma_rd <= 1'b1;
			@(posedge clk_i);
			dma_rd <= 1'b0;
			@(posedge clk_i);
			chk(dma_rdat, base + i[7:0]);
		end
	endtask
	task automatic out_dma;
		wb(1'b1, 4'h0, 32'h44);
		i_host.send(2, 8'h20);
		// flag cleared, DMA drains, then busy cleared
		wb(1'b1, 4'h5, 32'h1);
		dma_drain(2, 8'h20);
		wb(1'b0, 4'h1, 32'h0);
		chk(q[3:0], 4'h4);
		wb(1'b1, 4'h5, 32'h4);
		wb(1'b0, 4'h1, 32'h0);
		chk(q[2:0], 3'h0);
		wb(1'b1, 4'h0, 32'h46);
		i_host.send(2, 8'h30);
		// busy clear ignored while DMA switches banks
		wb(1'b1, 4'h5, 32'h5);
		wb(1'b0, 4'h1, 32'h0);
		chk(q[2:0], 3'h4);
		dma_drain(2, 8'h30);
		wb(1'b0, 4'h1, 32'h0);
		chk(q[3:2], 2'h0);
		i_host.send(0, 8'h00);
		wb(1'b0, 4'h1, 32'h0);
		chk({q[4], q[0]}, 2'h2);
	endtask
	task automatic final_report;
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		do_reset;
		in_manual;
		do_reset;
		out_manual;
		do_reset;
		overflow;
		do_reset;
		out_dma;
		final_report;
	end
	initial begin
		#400000;
		failures++;
		final_report;
	end
endmodule // tb_usb_endpoint_bank_manager
